//--- rtl/stream_write_pkg.sv
// Purpose: Shared constants and types for the streaming PIO write command block
// Assumes: 8-bit register port, 50 MHz clock
// Notes: Register offsets are byte indices on the plain register port
package stream_write_pkg;
  localparam int ADDR_W = 5;
  localparam int LBA_W = 48;
  localparam int STREAMS = 8;
  // Register offsets
  localparam logic [4:0] OFS_FEAT_CUR = 5'h01;
  localparam logic [4:0] OFS_FEAT_PREV = 5'h02;
  localparam logic [4:0] OFS_CNT_CUR = 5'h03;
  localparam logic [4:0] OFS_CNT_PREV = 5'h04;
  localparam logic [4:0] OFS_LBA0 = 5'h05;
  localparam logic [4:0] OFS_LBA5 = 5'h0A;
  localparam logic [4:0] OFS_CMD_STAT = 5'h0B;
  localparam logic [4:0] OFS_ERROR = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0D;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h0E;
  localparam logic [4:0] OFS_UNIT_LO = 5'h0F;
  localparam logic [4:0] OFS_UNIT_HI = 5'h10;
  localparam logic [4:0] OFS_MIN_LO = 5'h11;
  localparam logic [4:0] OFS_MIN_HI = 5'h12;
  localparam logic [4:0] OFS_DEF_BASE = 5'h18;
  localparam logic [7:0] OPC_WRITE_STREAM = 8'h3B;
  // Status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SE = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // Error bit positions
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int ER_TIME_LIMIT_EXPIRED_FLAG = 0;
  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_SERR = 2;
  localparam logic [16:0] MAX_SECTORS = 17'h10000;
  localparam logic [15:0] UNIT_RESET = 16'h0001;
  localparam logic [15:0] MIN_COMPLETION_TIME_LIMIT_RESET = 16'h0001;
  localparam int CLK_MHZ = 50;
  localparam int US_PER_TICK = 1;
  localparam int CYC_PER_US = CLK_MHZ * US_PER_TICK;

  typedef struct packed {
    logic urgent;
    logic writeContinuous;
    logic flush;
    logic handleStreamError;
    logic reserved;
    logic [2:0] streamIdentifier;
  } feature_s;

  typedef struct packed {
    logic done;
    logic error;
    logic errIdnf;
  } sector_s;
endpackage

//--- rtl/stream_pio_write_command.sv
// Purpose: Device-side interpreter of the streaming PIO write command
// Assumes: media path reports one sector result per pulse, same clock
// Notes: Completion time limit checked at sector boundaries only
//
// Overview of operation
// - Write count sectors, zero means 65536
// - Continuous mode never aborts on errors
// - Continuous errors end SE set, ERR clear
// - Continuous timeout stops, sets expired flag
// - Continuous mode attempts full transfer within limit
// - Urgent flag requests minimum-time completion
// - Flush flag commits stream before completion
// - Handle-error flag restarts at last error
// - Low three feature bits select stream
// - Limit is multiplier times identify time unit
// - Zero multiplier uses stream default limit
// - No default means limit ignored
// - Limit timed from command write to completion
// - Limit raised to device minimum
// - Timeout sets error register bit zero
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module stream_pio_write_command #(
  parameter int LBA_W = stream_write_pkg::LBA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [stream_write_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Media path
  input wire stream_write_pkg::sector_s sectorResult,
  input wire logic flushDone,
  output logic xferActive,
  output logic [LBA_W-1:0] startLba,
  output logic [2:0] streamIdentifier,
  output logic urgentReq,
  output logic flushReq,
  // Interrupt
  output logic irq
);
  import stream_write_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_XFER = 4'b0010,
    S_FLUSH = 4'b0100,
    S_END = 4'b1000
  } state_e;

  state_e state_q;
  feature_s featCur_q;
  logic [7:0] featPrev_q;
  logic [15:0] count_q;
  logic [LBA_W-1:0] lba_q;
  logic [7:0] status_q;
  logic [7:0] error_q;
  logic [2:0] irqStat_q;
  logic [2:0] irqMask_q;
  logic [15:0] unit_q;
  logic [15:0] minCctl_q;
  logic [7:0] defCctl_q [STREAMS];
  logic [STREAMS-1:0] defValid_q;
  logic [LBA_W-1:0] errLba_q [STREAMS];
  feature_s run_q;
  logic [16:0] remain_q;
  logic [LBA_W-1:0] curLba_q;
  logic sawError_q;
  logic sawIdnf_q;
  logic timerOn_q;
  logic [23:0] usLeft_q;
  logic [5:0] presc_q;
  logic [7:0] rdata_d;

  logic cmdWrite;
  logic sectorBoundary;
  logic expired;
  logic lastSector;
  logic [7:0] multSel;
  logic [23:0] limitRaw;
  logic [23:0] limit_d;
  logic limitOn_d;
  logic endPulse;
  logic timeoutEnd;
  logic abortEnd;

  assign cmdWrite = regWr && regAddr == OFS_CMD_STAT && regWdata == OPC_WRITE_STREAM
                    && state_q == S_IDLE;
  assign sectorBoundary = state_q == S_XFER && sectorResult.done;
  assign expired = timerOn_q && usLeft_q == 24'h000000;
  assign lastSector = remain_q == 17'h00001;
  assign timeoutEnd = sectorBoundary && expired;
  assign abortEnd = sectorBoundary && !expired && sectorResult.error && !run_q.writeContinuous;

  // Limit computation at command write
  always_comb begin
    multSel = featPrev_q;
    limitOn_d = 1'b1;
    if (featPrev_q == 8'h00) begin
      multSel = defCctl_q[featCur_q.streamIdentifier];
      if (!defValid_q[featCur_q.streamIdentifier] || multSel == 8'h00) begin
        limitOn_d = 1'b0;
      end
    end
    limitRaw = 24'(multSel) * 24'(unit_q);
    limit_d = limitRaw;
    if (limitRaw < 24'(minCctl_q)) begin
      limit_d = 24'(minCctl_q);
    end
  end

  // Task file and configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      featCur_q <= '0;
      featPrev_q <= 8'h00;
      count_q <= 16'h0000;
      lba_q <= '0;
      unit_q <= UNIT_RESET;
      minCctl_q <= MIN_COMPLETION_TIME_LIMIT_RESET;
      irqMask_q <= 3'h0;
    end else if (regWr && state_q == S_IDLE) begin
      case (regAddr)
        OFS_FEAT_CUR: featCur_q <= regWdata;
        OFS_FEAT_PREV: featPrev_q <= regWdata;
        OFS_CNT_CUR: count_q[7:0] <= regWdata;
        OFS_CNT_PREV: count_q[15:8] <= regWdata;
        OFS_IRQ_MASK: irqMask_q <= regWdata[2:0];
        OFS_UNIT_LO: unit_q[7:0] <= regWdata;
        OFS_UNIT_HI: unit_q[15:8] <= regWdata;
        OFS_MIN_LO: minCctl_q[7:0] <= regWdata;
        OFS_MIN_HI: minCctl_q[15:8] <= regWdata;
        default: begin
          if (regAddr >= OFS_LBA0 && regAddr <= OFS_LBA5) begin
            lba_q[8*(regAddr-OFS_LBA0) +: 8] <= regWdata;
          end
        end
      endcase
    end else if (regWr && regAddr == OFS_IRQ_MASK) begin
      irqMask_q <= regWdata[2:0];
    end
  end

  // Per-stream default limits and last error addresses
  genvar g;
  generate
    for (g = 0; g < STREAMS; g++) begin : g_stream
      always_ff @(posedge clk) begin
        if (rst) begin
          defCctl_q[g] <= 8'h00;
          defValid_q[g] <= 1'b0;
        end else if (regWr && regAddr == OFS_DEF_BASE + 5'(g)) begin
          defCctl_q[g] <= regWdata;
          defValid_q[g] <= 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          errLba_q[g] <= '0;
        end else if (sectorBoundary && sectorResult.error && run_q.streamIdentifier == 3'(g)) begin
          errLba_q[g] <= curLba_q;
        end
      end
    end
  endgenerate

  // Command sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      run_q <= '0;
      remain_q <= 17'h00000;
      curLba_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmdWrite) begin
            state_q <= S_XFER;
            run_q <= featCur_q;
            remain_q <= (count_q == 16'h0000) ? MAX_SECTORS : {1'b0, count_q};
            curLba_q <= featCur_q.handleStreamError ? errLba_q[featCur_q.streamIdentifier] : lba_q;
          end
        end
        S_XFER: begin
          if (sectorBoundary) begin
            curLba_q <= curLba_q + 1'b1;
            remain_q <= remain_q - 17'h00001;
            if (timeoutEnd || abortEnd) begin
              state_q <= S_END;
            end else if (lastSector) begin
              state_q <= run_q.flush ? S_FLUSH : S_END;
            end
          end
        end
        S_FLUSH: begin
          if (flushDone) begin
            state_q <= S_END;
          end
        end
        S_END: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Error accumulation for continuous mode
  always_ff @(posedge clk) begin
    if (rst || cmdWrite) begin
      sawError_q <= 1'b0;
      sawIdnf_q <= 1'b0;
    end else if (sectorBoundary && sectorResult.error) begin
      sawError_q <= 1'b1;
      sawIdnf_q <= sawIdnf_q | sectorResult.errIdnf;
    end
  end

  // Microsecond completion timer
  always_ff @(posedge clk) begin
    if (rst) begin
      timerOn_q <= 1'b0;
      usLeft_q <= 24'h000000;
      presc_q <= 6'h00;
    end else if (cmdWrite) begin
      timerOn_q <= limitOn_d;
      usLeft_q <= limit_d;
      presc_q <= 6'h00;
    end else if (state_q == S_IDLE) begin
      timerOn_q <= 1'b0;
    end else if (presc_q == 6'(CYC_PER_US - 1)) begin
      presc_q <= 6'h00;
      if (usLeft_q != 24'h000000) begin
        usLeft_q <= usLeft_q - 24'h000001;
      end
    end else begin
      presc_q <= presc_q + 6'h01;
    end
  end

  assign endPulse = (state_q == S_END);

  // Status and error registers
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
      error_q <= 8'h00;
    end else if (cmdWrite) begin
      status_q <= 8'h00;
      status_q[ST_BSY] <= 1'b1;
      status_q[ST_RDY] <= 1'b1;
      status_q[ST_DRQ] <= 1'b1;
      error_q <= 8'h00;
    end else if (timeoutEnd) begin
      status_q[ST_BSY] <= 1'b0;
      status_q[ST_DRQ] <= 1'b0;
      status_q[ST_SE] <= 1'b1;
      status_q[ST_ERR] <= !run_q.writeContinuous;
      error_q[ER_TIME_LIMIT_EXPIRED_FLAG] <= 1'b1;
      error_q[ER_IDN] <= sawIdnf_q || (sectorResult.error && sectorResult.errIdnf);
      error_q[ER_ABT] <= (sawError_q && !sawIdnf_q) || (sectorResult.error && !sectorResult.errIdnf);
    end else if (abortEnd) begin
      status_q[ST_BSY] <= 1'b0;
      status_q[ST_DRQ] <= 1'b0;
      status_q[ST_ERR] <= 1'b1;
      error_q[ER_IDN] <= sectorResult.errIdnf;
      error_q[ER_ABT] <= !sectorResult.errIdnf;
    end else if (sectorBoundary && lastSector) begin
      status_q[ST_DRQ] <= 1'b0;
      if (!run_q.flush) begin
        status_q[ST_BSY] <= 1'b0;
        status_q[ST_SE] <= sawError_q || sectorResult.error;
        status_q[ST_ERR] <= 1'b0;
        error_q[ER_IDN] <= sawIdnf_q || (sectorResult.error && sectorResult.errIdnf);
        error_q[ER_ABT] <= (sawError_q && !sawIdnf_q) || (sectorResult.error && !sectorResult.errIdnf);
      end
    end else if (state_q == S_FLUSH && flushDone) begin
      status_q[ST_BSY] <= 1'b0;
      status_q[ST_SE] <= sawError_q;
      status_q[ST_ERR] <= 1'b0;
      error_q[ER_IDN] <= sawIdnf_q;
      error_q[ER_ABT] <= sawError_q && !sawIdnf_q;
    end else if (state_q == S_IDLE) begin
      status_q[ST_RDY] <= 1'b1;
    end
  end

  // Sticky interrupt status, set beats write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (regWr && regAddr == OFS_IRQ_STAT && regWdata[i]) begin
          irqStat_q[i] <= 1'b0;
        end
      end
      if (endPulse) begin
        irqStat_q[IRQ_DONE] <= 1'b1;
      end
      if (timeoutEnd) begin
        irqStat_q[IRQ_TIMEOUT] <= 1'b1;
      end
      if (endPulse && status_q[ST_SE]) begin
        irqStat_q[IRQ_SERR] <= 1'b1;
      end
    end
  end

  // Read mux, data one cycle after strobe
  always_comb begin
    rdata_d = 8'h00;
    case (regAddr)
      OFS_CMD_STAT: rdata_d = status_q;
      OFS_ERROR: rdata_d = error_q;
      OFS_IRQ_STAT: rdata_d = {5'h00, irqStat_q};
      OFS_IRQ_MASK: rdata_d = {5'h00, irqMask_q};
      OFS_FEAT_CUR: rdata_d = featCur_q;
      OFS_FEAT_PREV: rdata_d = featPrev_q;
      OFS_CNT_CUR: rdata_d = count_q[7:0];
      OFS_CNT_PREV: rdata_d = count_q[15:8];
      OFS_UNIT_LO: rdata_d = unit_q[7:0];
      OFS_UNIT_HI: rdata_d = unit_q[15:8];
      OFS_MIN_LO: rdata_d = minCctl_q[7:0];
      OFS_MIN_HI: rdata_d = minCctl_q[15:8];
      default: begin
        if (regAddr >= OFS_DEF_BASE) begin
          rdata_d = defCctl_q[3'(regAddr - OFS_DEF_BASE)];
        end else if (regAddr >= OFS_LBA0 && regAddr <= OFS_LBA5) begin
          rdata_d = lba_q[8*(regAddr-OFS_LBA0) +: 8];
        end
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
      irq <= 1'b0;
      xferActive <= 1'b0;
      startLba <= '0;
      streamIdentifier <= 3'h0;
      urgentReq <= 1'b0;
      flushReq <= 1'b0;
    end else begin
      regRdata <= regRd ? rdata_d : 8'h00;
      irq <= |(irqStat_q & irqMask_q);
      xferActive <= state_q == S_XFER && !(sectorBoundary && (lastSector || timeoutEnd || abortEnd));
      startLba <= curLba_q;
      streamIdentifier <= run_q.streamIdentifier;
      urgentReq <= run_q.urgent && state_q != S_IDLE && state_q != S_END;
      flushReq <= state_q == S_FLUSH && !flushDone;
    end
  end

  // Checks
  zero_count_a: assert property (@(posedge clk) disable iff (rst)
    cmdWrite && count_q == 16'h0000 |=> remain_q == MAX_SECTORS) else $error("zero count not 65536");
  wc_noabort_a: assert property (@(posedge clk) disable iff (rst)
    sectorBoundary && sectorResult.error && run_q.writeContinuous && !expired && !lastSector
    |=> state_q == S_XFER) else $error("continuous mode aborted");
  wc_endstat_a: assert property (@(posedge clk) disable iff (rst)
    state_q == S_END && run_q.writeContinuous && sawError_q && !error_q[ER_TIME_LIMIT_EXPIRED_FLAG]
    |-> status_q[ST_SE] && !status_q[ST_ERR] && !status_q[ST_BSY]) else $error("bad continuous end status");
  timeout_stop_a: assert property (@(posedge clk) disable iff (rst)
    timeoutEnd |=> state_q == S_END ##1 state_q == S_IDLE) else $error("timeout did not stop");
  time_limit_expired_flag_bit_a: assert property (@(posedge clk) disable iff (rst)
    timeoutEnd |=> error_q[ER_TIME_LIMIT_EXPIRED_FLAG] && !status_q[ST_BSY]) else $error("expiry flag not set");
  flush_wait_a: assert property (@(posedge clk) disable iff (rst)
    state_q == S_FLUSH && !flushDone |=> status_q[ST_BSY]) else $error("completion before flush");
  no_limit_a: assert property (@(posedge clk) disable iff (rst)
    cmdWrite && featPrev_q == 8'h00 && !defValid_q[featCur_q.streamIdentifier] |=> !timerOn_q)
    else $error("limit used without default");
  min_clamp_a: assert property (@(posedge clk) disable iff (rst)
    cmdWrite && limitOn_d |=> usLeft_q >= 24'($past(minCctl_q))) else $error("limit below minimum");
  hse_start_a: assert property (@(posedge clk) disable iff (rst)
    cmdWrite && featCur_q.handleStreamError |=> curLba_q == $past(errLba_q[featCur_q.streamIdentifier]))
    else $error("resume address wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    |(irqStat_q & irqMask_q) |=> irq) else $error("interrupt not raised");
  timeout_c: cover property (@(posedge clk) disable iff (rst) timeoutEnd && run_q.writeContinuous);
  flush_c: cover property (@(posedge clk) disable iff (rst) state_q == S_FLUSH ##1 state_q == S_END);
  wc_err_c: cover property (@(posedge clk) disable iff (rst) state_q == S_END && sawError_q);
endmodule

//--- bench/media_model.sv
// Purpose: Media side partner answering sector results and flushes
// Assumes: one clock, sectors only while xferActive
// Notes: Idle result fields toggle so a stale value is never trusted
`timescale 1ns/1ns
module media_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the block
  input wire logic xferActive,
  input wire logic flushReq,
  // Bench controls
  input wire integer delay,
  input wire integer errAt,
  input wire logic errIdnf,
  // To the block, and the accepted count to the bench
  output stream_write_pkg::sector_s sectorResult = '0,
  output logic flushDone = 1'b0,
  output int accepted = 0
);
  import stream_write_pkg::*;
  int waitN;
  int sent;
  int flushWait;
  always @(posedge clk) begin
    if (rst) begin
      sectorResult <= '0;
      flushDone <= 1'b0;
      accepted <= 0;
      sent <= 0;
      waitN <= 0;
      flushWait <= 0;
    end else begin
      // A pulse counts only if the block was taking sectors
      if (sectorResult.done && xferActive) begin
        accepted <= accepted + 1;
      end
      if (xferActive && waitN == 0) begin
        sectorResult <= '{1'b1, sent == errAt, errIdnf};
      end else begin
        sectorResult <= '{1'b0, ~sectorResult.error, ~sectorResult.errIdnf};
      end
      flushDone <= flushReq && flushWait == 0;
      if (!xferActive) begin
        sent <= 0;
        waitN <= delay;
      end else if (waitN > 0) begin
        waitN <= waitN - 1;
      end else begin
        sent <= sent + 1;
        waitN <= delay;
      end
      if (!flushReq) begin
        flushWait <= delay;
      end else if (flushWait > 0) begin
        flushWait <= flushWait - 1;
      end
    end
  end
endmodule

//--- bench/test_stream_pio_write_command.sv
// Purpose: Self-checking bench for the streaming write command block
// Assumes: media model answers every sector and flush
// Notes: Expiry windows allow one microsecond tick of slack
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module test_stream_pio_write_command;
  import stream_write_pkg::*;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, errIdnf = 1'b0;
  logic flushDone, xferActive, urgentReq, flushReq, irq;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWdata = 8'h00, regRdata, d, st, er;
  sector_s sectorResult;
  logic [LBA_W-1:0] startLba, lba, elba;
  logic [2:0] streamIdentifier;
  logic [15:0] cnts [3] = '{16'h0100, 16'h0000, 16'h0001};
  int n_fail = 0, comparisons = 0, seed = 23, delay = 0, errAt = -1, accepted, base, k;
  always #10 clk = ~clk;

  stream_pio_write_command u_stream_pio_write_command (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sectorResult(sectorResult),
    .flushDone(flushDone), .xferActive(xferActive), .startLba(startLba), .streamIdentifier(streamIdentifier),
    .urgentReq(urgentReq), .flushReq(flushReq), .irq(irq));
  media_model u_media_model (.clk(clk), .rst(rst), .xferActive(xferActive), .flushReq(flushReq),
    .delay(delay), .errAt(errAt), .errIdnf(errIdnf), .sectorResult(sectorResult), .flushDone(flushDone),
    .accepted(accepted));

  function automatic int lim_us(int m, int u, int mn, int df);
    int t;
    t = (m != 0) ? m * u : df * u;
    return (t == 0) ? 0 : ((t < mn) ? mn : t);
  endfunction

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic cmd(input logic [7:0] f, input logic [7:0] m, input logic [15:0] n);
    lba = LBA_W'({$random(seed), $random(seed)});
    base = accepted;
    wr(OFS_FEAT_CUR, f);
    wr(OFS_FEAT_PREV, m);
    wr(OFS_CNT_CUR, n[7:0]);
    wr(OFS_CNT_PREV, n[15:8]);
    for (int i = 0; i < 6; i++) wr(OFS_LBA0 + 5'(i), lba[8*i +: 8]);
    wr(OFS_CMD_STAT, OPC_WRITE_STREAM);
  endtask

  task automatic finish_cmd;
    k = 0;
    rd(OFS_CMD_STAT);
    while (d[ST_BSY] !== 1'b0 && k++ < 34000) rd(OFS_CMD_STAT);
    `CHK("busy cleared", 1'b0, d[ST_BSY])
    st = d;
    rd(OFS_ERROR);
    er = d;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tl(input logic [7:0] f, input logic [7:0] m, input logic [7:0] u, input logic [7:0] mn,
                    input logic [7:0] df);
    int e;
    wr(OFS_UNIT_LO, u);
    wr(OFS_MIN_LO, mn);
    e = lim_us(m, u, mn, df) * CYC_PER_US / (delay + 1);
    wr(OFS_IRQ_STAT, 8'h07);
    cmd(f, m, 16'h003C);
    finish_cmd;
    `CHK("sectors in limit", 1'b1, (e == 0) ? (accepted - base == 60) : ((accepted - base) inside {[e-6:e+2]}))
    `CHK("limit status", {1'b0, e != 0, 1'b0, e != 0}, {st[ST_BSY], st[ST_SE], st[ST_ERR], er[ER_TIME_LIMIT_EXPIRED_FLAG]})
    `CHK("expiry flag", e != 0, er[ER_TIME_LIMIT_EXPIRED_FLAG])
    `CHK("stopped early", e != 0, accepted - base < 60)
    rd(OFS_IRQ_STAT);
    `CHK("timeout irq", e != 0, d[IRQ_TIMEOUT])
    `CHK("stream error irq", e != 0, d[IRQ_SERR])
    $display("limit test done, %0d sectors", accepted - base);
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CMD_STAT);
    `CHK("status after reset", 8'(1 << ST_RDY), d)
    rd(5'h13);
    `CHK("unmapped read", 8'h00, d)
    wr(OFS_IRQ_MASK, 8'h01);
    delay = 4;
    for (int s = 0; s < 8; s++) begin
      cmd({s[0], 4'h0, s[2:0]}, 8'h00, 16'h0002);
      repeat (3) @(posedge clk);
      #1;
      `CHK("stream_identifier", 3'(s), streamIdentifier)
      `CHK("urgent", s[0], urgentReq)
      finish_cmd;
      `CHK("sectors", 2, accepted - base)
      `CHK("irq raised", 1'b1, irq)
      wr(OFS_IRQ_STAT, 8'h07);
      repeat (2) @(posedge clk);
      #1;
      `CHK("irq cleared", 1'b0, irq)
    end
    wr(OFS_IRQ_MASK, 8'h00);
    cmd(8'h05, 8'h00, 16'h0001);
    finish_cmd;
    `CHK("irq masked", 1'b0, irq)
    rd(OFS_IRQ_STAT);
    `CHK("done sticky", 1'b1, d[IRQ_DONE])
    wr(OFS_IRQ_STAT, 8'h07);
    $display("stream and interrupt test done");
    delay = 0;
    foreach (cnts[i]) begin
      cmd(8'h07, 8'h00, cnts[i]);
      finish_cmd;
      `CHK("sector count", (cnts[i] == 16'h0000) ? 65536 : int'(cnts[i]), accepted - base)
    end
    $display("count test done");
    delay = 1;
    errAt = 3;
    for (int i = 0; i < 2; i++) begin
      errIdnf = i[0];
      cmd(8'h41, 8'h00, 16'h0008);
      elba = lba + 3;
      finish_cmd;
      `CHK("continuous sectors", 8, accepted - base)
      `CHK("continuous status", 3'b010, {st[ST_BSY], st[ST_SE], st[ST_ERR]})
      `CHK("error type", {i[0], ~i[0]}, {er[ER_IDN], er[ER_ABT]})
    end
    errAt = -1;
    delay = 20;
    cmd(8'h51, 8'h00, 16'h0002);
    repeat (3) @(posedge clk);
    #1;
    `CHK("resume address", elba, startLba)
    finish_cmd;
    $display("continuous error test done");
    delay = 6;
    cmd(8'h22, 8'h00, 16'h0003);
    k = 0;
    while (flushReq !== 1'b1 && k++ < 200) @(posedge clk);
    `CHK("flush requested", 1'b1, flushReq)
    rd(OFS_CMD_STAT);
    `CHK("busy during flush", 1'b1, d[ST_BSY])
    finish_cmd;
    `CHK("flush ended", 1'b0, flushReq)
    $display("flush test done");
    delay = 9;
    tl(8'h46, 8'h00, 8'h01, 8'h01, 8'h00);
    wr(OFS_DEF_BASE + 5'h02, 8'h00);
    tl(8'h42, 8'h00, 8'h01, 8'h01, 8'h00);
    wr(OFS_DEF_BASE + 5'h03, 8'h04);
    tl(8'h43, 8'h00, 8'h01, 8'h01, 8'h04);
    tl(8'h43, 8'h02, 8'h03, 8'h01, 8'h04);
    tl(8'h43, 8'h01, 8'h01, 8'h05, 8'h04);
    end_sim;
  end

  initial begin
    repeat (99000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule
